// [rtl/bps_pkg.sv]
package bps_pkg;

   // Core clock rate and the bus-undervoltage qualification time
   localparam int unsigned CORE_CLK_KHZ = 10000;
   localparam int unsigned BUS_FILTER_US = 2000;
   localparam int unsigned BUS_FILTER_CYC = (BUS_FILTER_US * CORE_CLK_KHZ) / 1000;
   localparam int unsigned BUS_CNT_W = 16;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CONFIG = 8'h08;

   // Control register fields and reset value
   localparam int unsigned CTRL_CLK_EN_BIT = 0;
   localparam int unsigned CTRL_RAIL_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   // Status and config register field positions
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_CLKSRC_LSB = 4;
   localparam int unsigned ST_FLAGS_LSB = 8;
   localparam int unsigned ST_OUTS_LSB = 20;
   localparam int unsigned CFG_FAST_BIT = 0;

   // Number of synchronised pins
   localparam int unsigned PIN_W = 16;
   // Edges a pin needs to cross the synchroniser
   localparam int unsigned SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      BPS_RESET,
      BPS_STARTUP,
      BPS_STANDBY,
      BPS_NORMAL
   } bps_state_t;

   // Source steering for the host clock mux
   typedef enum logic [1:0] {
      BPS_CLK_OFF,
      BPS_CLK_INT4,
      BPS_CLK_XTAL8,
      BPS_CLK_XTAL16
   } bps_clk_src_t;

   // Supervisor and status flags, all active high
   typedef struct packed {
      logic bus_ok;
      logic filt_start;
      logic filt_high;
      logic filt_warn_ok;
      logic filt_reset_ok;
      logic fixed_rail_ok;
      logic adj_rail_ok;
      logic linreg_ok;
      logic thermal_warn;
      logic thermal_shutdown;
      logic xtal_ok;
      logic calib_done;
   } bps_sup_t;

   // Host-side control pins and the current-configuration strap
   typedef struct packed {
      logic host_clock_select;
      logic buck2_enable_low;
      logic linreg_enable_low;
      logic strap_hard_low;
   } bps_pins_t;

endpackage

// [rtl/bps_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pins
module bps_sync (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Data
   input wire logic [bps_pkg::PIN_W-1:0] i_async,
   output logic [bps_pkg::PIN_W-1:0] o_sync
);

   logic [bps_pkg::PIN_W-1:0] meta_q;
   logic [bps_pkg::PIN_W-1:0] sync_q;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (i_clk_en) begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

// [rtl/bps_bus_timer.sv]
`timescale 1ns/1ps
// Qualifies a low bus-voltage flag over a fixed number of cycles
module bps_bus_timer #(
   parameter int unsigned P_CYCLES = bps_pkg::BUS_FILTER_CYC
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Flag in, qualified low out
   input wire logic i_bus_ok,
   output logic o_bus_low
);

   localparam logic [bps_pkg::BUS_CNT_W-1:0] LAST = bps_pkg::BUS_CNT_W'(P_CYCLES - 1);

   logic [bps_pkg::BUS_CNT_W-1:0] cnt_q;
   logic [bps_pkg::BUS_CNT_W-1:0] cnt_d;
   logic low_q;
   logic low_d;
   wire expired = (cnt_q == LAST);

   assign cnt_d = i_bus_ok ? '0 : (expired ? cnt_q : cnt_q + 1'b1);
   assign low_d = !i_bus_ok && expired;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
         low_q <= 1'b0;
      end else if (i_clk_en) begin
         cnt_q <= cnt_d;
         low_q <= low_d;
      end
   end

   assign o_bus_low = low_q;

endmodule

// [rtl/bps_sequencer.sv]
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Fixed buck turns on by itself once start-up begins, no enable pin.
// - Adjustable buck runs only while its low-active enable pin is low.
// - Linear 20 V regulator runs only while its low-active enable pin is low.
// - In standby after power-up the host clock is the internal 4 MHz.
// - Entering normal, host clock is 8 MHz if select low, else 16 MHz.
// - Falling to standby keeps crystal clock unless oscillator failed, then 4 MHz.
// - Warning goes low at once when filtered supply drops under 14 V.
// - Warning goes low after bus voltage stays under 20 V for 2 ms.
// - Host reset goes low when filtered supply drops under 12 V.
// - Host reset held low on low bus, dead fixed buck or thermal shutdown; the code holds it only on the last two, a low bus just drops to standby.
// - Host reset and warning are open-drain with internal pull-ups.
// - Power state chosen from bus, filtered, adjustable and 20 V supervisors.
// - Weak or open strap selects 0.5 mA/ms slopes and 30 mA start limit.
// - Strap hard to ground selects 1 mA/ms, 60 mA start, 20.5 mA normal.
// - After calibration read in start-up, enter standby and release host reset.
// - Normal state and warning release only when all four supervisors are good.
// - Thermal warning pulls the power-fail warning low.
module bps_sequencer #(
   parameter int unsigned P_BUS_FILTER_CYC = bps_pkg::BUS_FILTER_CYC
) (
   // Clock, reset and enable
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Supervisor flags and pins, asynchronous to the core clock
   input wire bps_pkg::bps_sup_t i_sup,
   input wire bps_pkg::bps_pins_t i_pins,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter enables
   output logic o_fixed_buck_en,
   output logic o_adjustable_buck_en,
   output logic o_linreg_en,
   // Host clock mux steering
   output bps_pkg::bps_clk_src_t o_host_clock_src,
   // Open-drain host pins; oe high while pulling low
   output logic o_host_reset_n_o,
   output logic o_host_reset_n_oe,
   output logic o_power_fail_warning_n_o,
   output logic o_power_fail_warning_n_oe,
   // Bus coupler current settings from the strap
   output logic o_slope_fast,
   output logic o_startup_limit_high,
   output logic o_normal_current_high
);

   localparam int unsigned SUP_W = $bits(bps_pkg::bps_sup_t);
   localparam int unsigned PIN_N = $bits(bps_pkg::bps_pins_t);

   // Synchronised inputs
   logic [bps_pkg::PIN_W-1:0] raw_w;
   logic [bps_pkg::PIN_W-1:0] sync_w;
   bps_pkg::bps_sup_t sup;
   bps_pkg::bps_pins_t pins;

   assign raw_w = {{(bps_pkg::PIN_W - SUP_W - PIN_N){1'b0}}, i_sup, i_pins};
   assign sup = sync_w[SUP_W+PIN_N-1:PIN_N];
   assign pins = sync_w[PIN_N-1:0];

   bps_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_async(raw_w),
      .o_sync(sync_w)
   );

   logic bus_low;

   bps_bus_timer #(
      .P_CYCLES(P_BUS_FILTER_CYC)
   ) u_bus_timer (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_bus_ok(sup.bus_ok),
      .o_bus_low(bus_low)
   );

   // State and registers
   bps_pkg::bps_state_t state_q;
   bps_pkg::bps_state_t state_d;
   bps_pkg::bps_clk_src_t clk_src_q;
   bps_pkg::bps_clk_src_t clk_src_d;
   logic [1:0] ctrl_q;
   logic strap_taken_q;
   logic strap_fast_q;
   logic fixed_en_q;
   logic adj_en_q;
   logic lin_en_q;
   logic rst_pull_q;
   logic warn_pull_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [1:0] settle_q;
   bps_pkg::bps_clk_src_t host_clk_q;

   // States in which the adjustable buck and linear regulator may run and the host reset is released
   function automatic logic state_up(input bps_pkg::bps_state_t s);
      state_up = (s == bps_pkg::BPS_STANDBY) || (s == bps_pkg::BPS_NORMAL);
   endfunction

   // One aligned word per offset, so a plain compare is the whole decode
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
      reg_hit = (addr == offset);
   endfunction

   // Supervisor decoding
   wire xtal_sel = pins.host_clock_select;
   wire bps_pkg::bps_clk_src_t xtal_src = xtal_sel ? bps_pkg::BPS_CLK_XTAL16
                                                   : bps_pkg::BPS_CLK_XTAL8;
   wire all_good = sup.bus_ok && sup.filt_warn_ok && sup.adj_rail_ok && sup.linreg_ok;
   wire drop_to_reset = sup.thermal_shutdown || !sup.filt_reset_ok || !sup.fixed_rail_ok;
   wire warn_cause = bus_low || !sup.filt_warn_ok || sup.thermal_warn;
   wire leave_normal = warn_cause || !sup.adj_rail_ok || !sup.linreg_ok || !sup.xtal_ok;
   wire rails_allowed = state_up(state_q) && sup.filt_high
                        && ctrl_q[bps_pkg::CTRL_RAIL_EN_BIT];

   // Power state machine
   always_comb begin
      state_d = state_q;
      clk_src_d = clk_src_q;
      case (state_q)
         bps_pkg::BPS_RESET: begin
            clk_src_d = bps_pkg::BPS_CLK_OFF;
            if (!sup.thermal_shutdown && sup.filt_start) begin
               state_d = bps_pkg::BPS_STARTUP;
            end
         end
         bps_pkg::BPS_STARTUP: begin
            if (sup.thermal_shutdown || !sup.filt_start) begin
               state_d = bps_pkg::BPS_RESET;
            // calibration read done; waiting out any reset cause
            // keeps standby from releasing the host reset for one cycle
            end else if (sup.fixed_rail_ok && sup.calib_done && !drop_to_reset) begin
               state_d = bps_pkg::BPS_STANDBY;
               clk_src_d = bps_pkg::BPS_CLK_INT4;
            end
         end
         bps_pkg::BPS_STANDBY: begin
            if (drop_to_reset) begin
               state_d = bps_pkg::BPS_RESET;
               clk_src_d = bps_pkg::BPS_CLK_OFF;
            end else if (all_good && !bus_low && !sup.thermal_warn && sup.xtal_ok) begin
               state_d = bps_pkg::BPS_NORMAL;
               clk_src_d = xtal_src;
            end
         end
         bps_pkg::BPS_NORMAL: begin
            if (drop_to_reset) begin
               state_d = bps_pkg::BPS_RESET;
               clk_src_d = bps_pkg::BPS_CLK_OFF;
            end else if (leave_normal) begin
               state_d = bps_pkg::BPS_STANDBY;
               if (!sup.xtal_ok) begin
                  clk_src_d = bps_pkg::BPS_CLK_INT4;
               end
            end
         end
         default: begin
            state_d = bps_pkg::BPS_RESET;
            clk_src_d = bps_pkg::BPS_CLK_OFF;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= bps_pkg::BPS_RESET;
         clk_src_q <= bps_pkg::BPS_CLK_OFF;
      end else if (i_clk_en) begin
         state_q <= state_d;
         clk_src_q <= clk_src_d;
      end
   end

   // Output drivers; all registered so pins never glitch
   wire fixed_en_d = (state_q != bps_pkg::BPS_RESET);
   wire adj_en_d = rails_allowed && !pins.buck2_enable_low;
   wire lin_en_d = rails_allowed && !pins.linreg_enable_low;
   wire rst_pull_d = !state_up(state_d);
   wire warn_pull_d = (state_d != bps_pkg::BPS_NORMAL) || warn_cause;
   // Software may silence the clock pin; the mux state itself keeps running
   wire bps_pkg::bps_clk_src_t host_clk_d =
      ctrl_q[bps_pkg::CTRL_CLK_EN_BIT] ? clk_src_q : bps_pkg::BPS_CLK_OFF;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fixed_en_q <= 1'b0;
         adj_en_q <= 1'b0;
         lin_en_q <= 1'b0;
         rst_pull_q <= 1'b1;
         warn_pull_q <= 1'b1;
         host_clk_q <= bps_pkg::BPS_CLK_OFF;
      end else if (i_clk_en) begin
         fixed_en_q <= fixed_en_d;
         adj_en_q <= adj_en_d;
         lin_en_q <= lin_en_d;
         rst_pull_q <= rst_pull_d;
         warn_pull_q <= warn_pull_d;
         host_clk_q <= host_clk_d;
      end
   end

   // Strap caught once after reset release, as the analog limits are fixed at start.
   // Capture waits for the synchroniser to fill, else it would latch its reset zeros.
   wire strap_ready = (settle_q == 2'(bps_pkg::SYNC_STAGES));

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         settle_q <= 2'h0;
         strap_taken_q <= 1'b0;
         strap_fast_q <= 1'b0;
      end else if (i_clk_en && !strap_taken_q) begin
         if (strap_ready) begin
            strap_taken_q <= 1'b1;
            strap_fast_q <= pins.strap_hard_low;
         end else begin
            settle_q <= settle_q + 2'h1;
         end
      end
   end

   // APB slave: no wait state, and every read answer still comes from a flop
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable && pready_q;
   // Unmapped offsets answer with an error and zero data; writes to them are dropped
   wire hit_ctrl = reg_hit(paddr, bps_pkg::ADDR_CTRL);
   wire hit_status = reg_hit(paddr, bps_pkg::ADDR_STATUS);
   wire hit_config = reg_hit(paddr, bps_pkg::ADDR_CONFIG);
   wire hit_any = hit_ctrl || hit_status || hit_config;
   wire wr_ctrl = access_ph && pwrite && hit_ctrl;

   logic [31:0] status_w;
   logic [31:0] rd_mux;

   assign status_w = {9'h000, fixed_en_q, adj_en_q, lin_en_q,
                      !rst_pull_q, !warn_pull_q, bus_low, sup.xtal_ok,
                      sup.thermal_shutdown, sup.thermal_warn, sup.linreg_ok, sup.adj_rail_ok,
                      sup.fixed_rail_ok, sup.filt_reset_ok, sup.filt_warn_ok, sup.bus_ok,
                      2'h0, clk_src_q, 2'h0, state_q};
   assign rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
                   hit_status ? status_w :
                   hit_config ? {31'h0, strap_fast_q} : 32'h0000_0000;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q <= bps_pkg::CTRL_RESET;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (i_clk_en) begin
         pready_q <= setup_ph;
         pslverr_q <= setup_ph && !hit_any;
         prdata_q <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
         if (wr_ctrl) begin
            ctrl_q <= pwdata[1:0];
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   assign o_fixed_buck_en = fixed_en_q;
   assign o_adjustable_buck_en = adj_en_q;
   assign o_linreg_en = lin_en_q;
   // Registered so the mux select never glitches on a control write
   assign o_host_clock_src = host_clk_q;
   assign o_host_reset_n_o = 1'b0;
   assign o_host_reset_n_oe = rst_pull_q;
   assign o_power_fail_warning_n_o = 1'b0;
   assign o_power_fail_warning_n_oe = warn_pull_q;
   assign o_slope_fast = strap_fast_q;
   assign o_startup_limit_high = strap_fast_q;
   assign o_normal_current_high = strap_fast_q;

endmodule

// [bench/bps_sequencer_props.sv]
`timescale 1ns/1ps
module bps_sequencer_props #(
   parameter int unsigned P_BUS_FILTER_CYC = bps_pkg::BUS_FILTER_CYC
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Watched inputs
   input wire bps_pkg::bps_sup_t i_sup,
   input wire bps_pkg::bps_pins_t i_pins,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   // Watched outputs
   input wire logic pready,
   input wire logic pslverr,
   input wire logic o_adjustable_buck_en,
   input wire logic o_linreg_en,
   input wire logic o_host_reset_n_o,
   input wire logic o_host_reset_n_oe,
   input wire logic o_power_fail_warning_n_o,
   input wire logic o_power_fail_warning_n_oe
);
   logic [15:0] low_cnt_q;
   logic [15:0] low_cnt_d;
   logic mapped;
   assign mapped = paddr == bps_pkg::ADDR_CTRL || paddr == bps_pkg::ADDR_STATUS
      || paddr == bps_pkg::ADDR_CONFIG;
   assign low_cnt_d = i_sup.bus_ok ? 16'h0 : low_cnt_q + 16'h1;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) low_cnt_q <= 16'h0;
      else low_cnt_q <= low_cnt_d;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   a_pready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
   a_pready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_slverr_unmapped: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
   a_pins_open_drain: assert property (!o_host_reset_n_o && !o_power_fail_warning_n_o)
      else $error("open-drain pin driven high");
   a_tsd_holds_reset: assert property (i_sup.thermal_shutdown [*4] |=> o_host_reset_n_oe)
      else $error("reset released in shutdown");
   a_filt_low_reset: assert property (!i_sup.filt_reset_ok [*4] |=> o_host_reset_n_oe)
      else $error("reset released on low supply");
   a_filt_low_warn: assert property (!i_sup.filt_warn_ok [*4] |=> o_power_fail_warning_n_oe)
      else $error("warning released on low supply");
   a_thermal_warn: assert property (i_sup.thermal_warn [*4] |=> o_power_fail_warning_n_oe)
      else $error("warning released while hot");
   a_bus_low_warn: assert property (low_cnt_q >= P_BUS_FILTER_CYC + 5 |-> o_power_fail_warning_n_oe)
      else $error("warning released on low bus");
   a_warn_after_reset: assert property (!o_power_fail_warning_n_oe |-> !o_host_reset_n_oe)
      else $error("warning high while reset low");
   a_buck2_pin_off: assert property (i_pins.buck2_enable_low [*5] |=> !o_adjustable_buck_en)
      else $error("buck on with pin high");
   a_linreg_pin_off: assert property (i_pins.linreg_enable_low [*5] |=> !o_linreg_en)
      else $error("regulator on with pin high");
endmodule

bind bps_sequencer bps_sequencer_props #(.P_BUS_FILTER_CYC(P_BUS_FILTER_CYC)) i_props (
   .i_core_clk, .i_sys_rst, .i_sup, .i_pins, .psel, .penable, .paddr, .pready, .pslverr,
   .o_adjustable_buck_en, .o_linreg_en, .o_host_reset_n_o, .o_host_reset_n_oe,
   .o_power_fail_warning_n_o, .o_power_fail_warning_n_oe);

// [bench/bps_host_model.sv]
`timescale 1ns/1ps
module bps_host_model (
   // Open-drain drives from the sequencer
   input wire logic i_reset_n_o,
   input wire logic i_reset_n_oe,
   input wire logic i_warn_n_o,
   input wire logic i_warn_n_oe,
   // Pin levels seen by the host
   output logic o_reset_n,
   output logic o_warn_n
);
   assign o_reset_n = i_reset_n_oe ? i_reset_n_o : 1'b1;
   assign o_warn_n = i_warn_n_oe ? i_warn_n_o : 1'b1;
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned P = 20;
   logic i_core_clk, i_sys_rst, i_clk_en, psel, penable, pwrite;
   bps_pkg::bps_sup_t i_sup;
   bps_pkg::bps_pins_t i_pins;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, o_fixed_buck_en, o_adjustable_buck_en, o_linreg_en;
   bps_pkg::bps_clk_src_t o_host_clock_src;
   logic o_host_reset_n_o, o_host_reset_n_oe, o_power_fail_warning_n_o;
   logic o_power_fail_warning_n_oe, o_slope_fast, o_startup_limit_high, o_normal_current_high;
   logic rst_pin_n, warn_pin_n;
   int bad_count = 0;
   int cmp_count = 0;
   bps_sequencer #(.P_BUS_FILTER_CYC(P)) i_bps_sequencer (.i_core_clk, .i_sys_rst, .i_clk_en,
      .i_sup, .i_pins, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .o_fixed_buck_en, .o_adjustable_buck_en, .o_linreg_en, .o_host_clock_src,
      .o_host_reset_n_o, .o_host_reset_n_oe, .o_power_fail_warning_n_o,
      .o_power_fail_warning_n_oe, .o_slope_fast, .o_startup_limit_high, .o_normal_current_high);
   bps_host_model i_bps_host_model (.i_reset_n_o(o_host_reset_n_o), .i_reset_n_oe(o_host_reset_n_oe),
      .i_warn_n_o(o_power_fail_warning_n_o), .i_warn_n_oe(o_power_fail_warning_n_oe),
      .o_reset_n(rst_pin_n), .o_warn_n(warn_pin_n));
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chs(input bps_pkg::bps_clk_src_t e);
      chk(32'(o_host_clock_src), 32'(e));
   endtask
   // Expected {reset pin, warning pin}
   task chp(input logic [1:0] e);
      chk(32'({rst_pin_n, warn_pin_n}), 32'(e));
   endtask
   task wt(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
         input logic [31:0] e, input logic ee);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      @(posedge i_core_clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge i_core_clk);
      end
      if (n == 20) bad_count++;
      if (!w) chk(prdata & m, e);
      chk(32'(pslverr), 32'(ee));
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task done(input string s);
      $display("test %0s finished at %0t", s, $time);
   endtask
   initial begin
      wt(5000);
      bad_count++;
      complete_run;
   end
   initial begin
      i_sys_rst = 1'b1;
      i_clk_en = 1'b1;
      i_sup = '0;
      i_pins = 4'hf;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      wt(20);
      i_sys_rst <= 1'b0;
      wt(5);
      chk(32'({o_slope_fast, o_startup_limit_high, o_normal_current_high}), 32'h7);
      chp(2'b00);
      i_sup.filt_start <= 1'b1;
      i_sup.filt_high <= 1'b1;
      i_sup.filt_warn_ok <= 1'b1;
      i_sup.filt_reset_ok <= 1'b1;
      i_sup.bus_ok <= 1'b1;
      i_sup.xtal_ok <= 1'b1;
      wt(6);
      chk(32'(o_fixed_buck_en), 32'h1);
      i_sup.fixed_rail_ok <= 1'b1;
      i_sup.calib_done <= 1'b1;
      wt(6);
      chp(2'b10);
      chs(bps_pkg::BPS_CLK_INT4);
      i_pins.buck2_enable_low <= 1'b0;
      i_pins.linreg_enable_low <= 1'b0;
      i_sup.adj_rail_ok <= 1'b1;
      i_sup.linreg_ok <= 1'b1;
      wt(6);
      chp(2'b11);
      chs(bps_pkg::BPS_CLK_XTAL16);
      chk(32'({o_adjustable_buck_en, o_linreg_en}), 32'h3);
      xfer(1'b0, bps_pkg::ADDR_STATUS, 32'h0, 32'h3, 32'h3, 1'b0);
      done("power up");
      xfer(1'b1, bps_pkg::ADDR_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, bps_pkg::ADDR_STATUS, 32'h0, 32'h3, 32'h3, 1'b0);
      xfer(1'b0, bps_pkg::ADDR_CTRL, 32'h0, 32'hffffffff, 32'h3, 1'b0);
      xfer(1'b0, 8'h0c, 32'h0, 32'hffffffff, 32'h0, 1'b1);
      xfer(1'b1, bps_pkg::ADDR_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
      wt(3);
      chk(32'({o_adjustable_buck_en, o_linreg_en}), 32'h0);
      xfer(1'b1, bps_pkg::ADDR_CTRL, 32'h2, 32'h0, 32'h0, 1'b0);
      wt(2);
      chs(bps_pkg::BPS_CLK_OFF);
      xfer(1'b1, bps_pkg::ADDR_CTRL, 32'h3, 32'h0, 32'h0, 1'b0);
      i_pins.buck2_enable_low <= 1'b1;
      wt(6);
      chk(32'({o_adjustable_buck_en, o_linreg_en}), 32'h1);
      done("registers");
      i_sup.bus_ok <= 1'b0;
      wt(P - 5);
      i_sup.bus_ok <= 1'b1;
      wt(10);
      chp(2'b11);
      i_sup.bus_ok <= 1'b0;
      wt(P + 8);
      chp(2'b10);
      chs(bps_pkg::BPS_CLK_XTAL16);
      i_sup.bus_ok <= 1'b1;
      wt(8);
      chp(2'b11);
      i_sup.xtal_ok <= 1'b0;
      wt(6);
      chs(bps_pkg::BPS_CLK_INT4);
      i_sup.xtal_ok <= 1'b1;
      wt(6);
      chp(2'b11);
      i_sup.filt_warn_ok <= 1'b0;
      wt(5);
      chp(2'b10);
      i_sup.filt_warn_ok <= 1'b1;
      wt(6);
      chp(2'b11);
      i_sup.thermal_warn <= 1'b1;
      wt(5);
      chp(2'b10);
      i_sup.thermal_warn <= 1'b0;
      wt(8);
      chp(2'b11);
      done("fallback");
      i_pins.host_clock_select <= 1'b0;
      i_sup.filt_reset_ok <= 1'b0;
      wt(5);
      chp(2'b00);
      i_sup.filt_reset_ok <= 1'b1;
      wt(14);
      chs(bps_pkg::BPS_CLK_XTAL8);
      i_clk_en <= 1'b0;
      i_sup.xtal_ok <= 1'b0;
      wt(6);
      chs(bps_pkg::BPS_CLK_XTAL8);
      i_sup.xtal_ok <= 1'b1;
      i_clk_en <= 1'b1;
      i_sup.thermal_shutdown <= 1'b1;
      wt(5);
      chp(2'b00);
      i_sup.thermal_shutdown <= 1'b0;
      i_pins.strap_hard_low <= 1'b0;
      wt(14);
      chp(2'b11);
      i_sys_rst <= 1'b1;
      wt(2);
      i_sys_rst <= 1'b0;
      wt(5);
      chk(32'({o_slope_fast, o_startup_limit_high, o_normal_current_high}), 32'h0);
      done("resets");
      complete_run;
   end
endmodule
